/* verilog/vpg_map.svh */
// register offsets, field positions, reset values and timing counts of the pattern generator
`ifndef VPG_MAP_SVH
`define VPG_MAP_SVH
`define VPG_OFF_CTL 12'h004
`define VPG_OFF_CFG 12'h008
`define VPG_OFF_CSI_DI 12'h00c
`define VPG_OFF_LINE_SIZE 12'h010
`define VPG_OFF_BAR_SIZE 12'h014
`define VPG_OFF_ACT_LPF 12'h018
`define VPG_OFF_TOT_LPF 12'h01c
`define VPG_OFF_LINE_PD 12'h020
`define VPG_OFF_VBP 12'h024
`define VPG_OFF_VFP 12'h028
`define VPG_OFF_STATUS 12'h02c
`define VPG_OFF_FIXED 12'h040
`define VPG_CTL_EN_BIT 0
`define VPG_CTL_SLOW_BIT 1
`define VPG_CFG_FIXED_BIT 7
`define VPG_CFG_INV_BIT 6
`define VPG_CFG_NBARS_LSB 4
`define VPG_CFG_BLK_LSB 0
`define VPG_RST_LINE_SIZE 16'h0f00
`define VPG_RST_BAR_SIZE 16'h01e0
`define VPG_RST_ACT_LPF 16'h02d0
`define VPG_RST_TOT_LPF 16'h041a
`define VPG_RST_LINE_PD 16'h0c67
`define VPG_RST_CSI_DI 8'h24
`define VPG_UNIT_FAST_NS 10
`define VPG_UNIT_SLOW_NS 20
`define VPG_CLK_NS 25
`define VPG_TICK_UNITS 5
`define VPG_DT_FS 6'h00
`define VPG_DT_FE 6'h01
`endif

/* verilog/vpg_pkg.sv */
// types shared by the pattern generator files
`default_nettype none
package vpg_pkg;
	typedef struct packed {
		logic valid;
		logic sop;
		logic eop;
		logic short_pkt;
		logic [1:0] vc;
		logic [5:0] dt;
		logic [15:0] wc;
		logic [7:0] data;
	} vpg_tx_t;
	typedef enum logic [2:0] {
		VPG_IDLE = 3'b000,
		VPG_FS = 3'b001,
		VPG_WAIT = 3'b011,
		VPG_HDR = 3'b010,
		VPG_DATA = 3'b110,
		VPG_FE = 3'b111
	} vpg_state_t;
endpackage : vpg_pkg
`default_nettype wire

/* verilog/vpg_tick.sv */
// line-period unit tick divider
`timescale 1ns/100ps
`default_nettype none
`include "vpg_map.svh"
module vpg_tick
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// control
	input wire logic slow_unit,
	output logic tick
);
	// a unit is shorter than a clock, so one tick stands for five units (50 or 100 ns),
	// a whole number of clocks: ticks stay evenly spaced and never pile up
	localparam logic [7:0] UNIT_F = 8'(`VPG_UNIT_FAST_NS);
	localparam logic [7:0] UNIT_S = 8'(`VPG_UNIT_SLOW_NS);
	localparam logic [7:0] CLK_NS = 8'(`VPG_CLK_NS);
	localparam logic [7:0] PER_TICK = 8'(`VPG_TICK_UNITS);
	logic [7:0] acc;
	logic [7:0] unit;
	logic [8:0] span;
	logic [8:0] sum;
	assign unit = slow_unit ? UNIT_S : UNIT_F;
	assign span = {1'b0, unit} * {1'b0, PER_TICK};
	assign sum = {1'b0, acc} + {1'b0, CLK_NS};
	// accumulate elapsed ns; one tick when a span of five units is complete
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			acc <= 8'h00;
			tick <= 1'b0;
		end
		else if (sum >= span)
		begin
			acc <= 8'(sum - span);
			tick <= 1'b1;
		end
		else
		begin
			acc <= sum[7:0];
			tick <= 1'b0;
		end
	end
	// tick spacing: two clocks for 10 ns units, four for 20 ns units
	property p_tick_fast; // [R6]
		@(posedge core_clk) disable iff (!rst_n)
		(tick && !slow_unit && acc == 8'h00) ##1 !slow_unit |-> !tick ##1 tick;
	endproperty
	a_tick_fast: assert property (p_tick_fast) else $error("fast unit tick spacing wrong"); // [R6]
	property p_tick_slow; // [R6]
		@(posedge core_clk) disable iff (!rst_n)
		(tick && slow_unit && acc == 8'h00) ##1 slow_unit[*3] |-> !tick ##1 tick;
	endproperty
	a_tick_slow: assert property (p_tick_slow) else $error("slow unit tick spacing wrong"); // [R6]
endmodule : vpg_tick
`default_nettype wire

/* verilog/vpg_top.sv */
// video pattern generator feeding the csi-2 transmitter, with apb registers
// How it works
// R1 - two modes, colour bars and fixed colour
// R2 - eight bars AA 33 F0 7F 55 CC 0F 80
// R3 - last bar stretches to fill line
// R4 - one, two, four or eight bars
// R5 - line, bar, dt, vc, lines programmable
// R6 - line period 10 ns, 20 ns slow; code times lines in 50 or 100 ns ticks, rounding line_pd up
// R7 - front porch blank lines before frame end
// R8 - back porch blank lines after frame start
// R9 - runs on transmit clock, direct output
// R10 - emits formatted frame and line packets
// R11 - software keeps bars block multiples
// R12 - fixed colour uses same geometry
// R13 - fixed colour alternates with complement per bar
// R14 - block up to 16 bytes, repeated
// R15 - sixteen byte registers hold block
// R16 - software disables forwarding first
// R17 - software sets transmitter speed first
// R18 - software picks whole-pixel block size
// R19 - next frame starts after total lines
// R20 - disable stops only after frame end
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "vpg_map.svh"
module vpg_top
#(
	parameter int BLK_MAX = 16
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// stream to csi-2 transmitter
	output vpg_pkg::vpg_tx_t tx,
	input wire logic tx_ready,
	// frame status
	output logic busy
);
	import vpg_pkg::*;
	if (BLK_MAX != 16)
		$error("vpg_top: block storage is fixed at 16 bytes");
	// register set
	logic ctl_en;
	logic ctl_slow;
	logic [7:0] cfg;
	logic [7:0] csi_di;
	logic [15:0] line_size;
	logic [15:0] bar_size;
	logic [15:0] act_lpf;
	logic [15:0] tot_lpf;
	logic [15:0] line_pd;
	logic [7:0] vbp;
	logic [7:0] vfp;
	logic [7:0] fixed_blk [16];
	logic [15:0] frame_cnt;

	logic wr;
	logic rd;
	logic hit;
	assign wr = psel && penable && pwrite;
	assign rd = psel && !penable && !pwrite;
	function automatic logic known(input logic [11:0] a);
		known = (a >= 12'(`VPG_OFF_CTL) && a <= 12'(`VPG_OFF_STATUS))
			|| (a >= 12'(`VPG_OFF_FIXED) && a < 12'(`VPG_OFF_FIXED + 64));
	endfunction : known
	assign hit = known({paddr[11:2], 2'b00});
	// register writes; one-cycle access phase, pready always high [R5] [R15]
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctl_en <= 1'b0;
			ctl_slow <= 1'b0;
			cfg <= 8'h00;
			csi_di <= `VPG_RST_CSI_DI;
			line_size <= `VPG_RST_LINE_SIZE;
			bar_size <= `VPG_RST_BAR_SIZE;
			act_lpf <= `VPG_RST_ACT_LPF;
			tot_lpf <= `VPG_RST_TOT_LPF;
			line_pd <= `VPG_RST_LINE_PD;
			vbp <= 8'h00;
			vfp <= 8'h00;
			for (int i = 0; i < 16; i++)
				fixed_blk[i] <= 8'h00;
		end
		else if (wr)
		begin
			case (paddr)
				`VPG_OFF_CTL:
				begin
					ctl_en <= pwdata[`VPG_CTL_EN_BIT];
					ctl_slow <= pwdata[`VPG_CTL_SLOW_BIT];
				end
				`VPG_OFF_CFG: cfg <= pwdata[7:0];
				`VPG_OFF_CSI_DI: csi_di <= pwdata[7:0];
				`VPG_OFF_LINE_SIZE: line_size <= pwdata[15:0];
				`VPG_OFF_BAR_SIZE: bar_size <= pwdata[15:0];
				`VPG_OFF_ACT_LPF: act_lpf <= pwdata[15:0];
				`VPG_OFF_TOT_LPF: tot_lpf <= pwdata[15:0];
				`VPG_OFF_LINE_PD: line_pd <= pwdata[15:0];
				`VPG_OFF_VBP: vbp <= pwdata[7:0];
				`VPG_OFF_VFP: vfp <= pwdata[7:0];
				default:
				begin
					if (paddr[11:6] == 6'(`VPG_OFF_FIXED >> 6))
						fixed_blk[paddr[5:2]] <= pwdata[7:0]; // [R15]
				end
			endcase
		end
	end
	// pready fixed high; read data captured in setup, valid in access phase
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= 1'b1;
			pslverr <= psel && !penable && !hit;
			if (rd)
			begin
				case (paddr)
					`VPG_OFF_CTL: prdata <= {30'h0, ctl_slow, ctl_en};
					`VPG_OFF_CFG: prdata <= {24'h0, cfg};
					`VPG_OFF_CSI_DI: prdata <= {24'h0, csi_di};
					`VPG_OFF_LINE_SIZE: prdata <= {16'h0, line_size};
					`VPG_OFF_BAR_SIZE: prdata <= {16'h0, bar_size};
					`VPG_OFF_ACT_LPF: prdata <= {16'h0, act_lpf};
					`VPG_OFF_TOT_LPF: prdata <= {16'h0, tot_lpf};
					`VPG_OFF_LINE_PD: prdata <= {16'h0, line_pd};
					`VPG_OFF_VBP: prdata <= {24'h0, vbp};
					`VPG_OFF_VFP: prdata <= {24'h0, vfp};
					`VPG_OFF_STATUS: prdata <= {frame_cnt, 15'h0, busy};
					default:
						prdata <= (paddr[11:6] == 6'(`VPG_OFF_FIXED >> 6))
							? {24'h0, fixed_blk[paddr[5:2]]} : 32'h0000_0000;
				endcase
			end
		end
	end
	// line period unit; slow bit selects 20 ns for the 400-Mb rate
	logic tick;
	vpg_tick u_tick
	(
		.core_clk(core_clk),
		.rst_n(rst_n),
		.slow_unit(ctl_slow), // [R6]
		.tick(tick)
	);
	// colour bar byte table
	function automatic logic [7:0] bar_byte(input logic [2:0] i);
		case (i)
			3'd0: bar_byte = 8'haa;
			3'd1: bar_byte = 8'h33;
			3'd2: bar_byte = 8'hf0;
			3'd3: bar_byte = 8'h7f;
			3'd4: bar_byte = 8'h55;
			3'd5: bar_byte = 8'hcc;
			3'd6: bar_byte = 8'h0f;
			default: bar_byte = 8'h80;
		endcase
	endfunction : bar_byte
	// sequencing state
	vpg_state_t state;
	logic [15:0] line_no;
	logic [15:0] pd_cnt;
	logic [15:0] byte_cnt;
	logic [15:0] bar_cnt;
	logic [2:0] bar_idx;
	logic [3:0] blk_idx;
	logic fe_pending;
	logic fe_sent;
	logic line_due;
	logic [2:0] nbars_m1;
	logic [3:0] blk_m1;
	logic in_active;
	logic [7:0] pix;
	logic accept;
	localparam logic [15:0] TICK_U = 16'(`VPG_TICK_UNITS);
	assign nbars_m1 = 3'((4'd1 << cfg[`VPG_CFG_NBARS_LSB +: 2]) - 4'd1); // [R4]
	assign blk_m1 = cfg[`VPG_CFG_BLK_LSB +: 4];
	assign accept = !tx.valid || tx_ready;
	// active window sits after the back porch [R8]
	assign in_active = line_no >= 16'(vbp) && line_no < 16'(vbp) + act_lpf;
	// the last bar keeps its byte to the end of the line [R3]
	assign pix = cfg[`VPG_CFG_FIXED_BIT]
		? (fixed_blk[blk_idx] ^ {8{cfg[`VPG_CFG_INV_BIT] & bar_idx[0]}}) // [R12] [R13]
		: bar_byte(bar_idx); // [R2]
	// line period timer; a tick is five units, so a line may run up to four units longer than line_pd
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			pd_cnt <= 16'h0000;
		else if (state == VPG_IDLE || state == VPG_FS)
			pd_cnt <= 16'h0000;
		else if (tick)
			pd_cnt <= (pd_cnt + TICK_U >= line_pd) ? 16'h0000 : pd_cnt + TICK_U; // [R6]
	end
	assign line_due = tick && (pd_cnt + TICK_U >= line_pd);

	// frame sequencer, transmit clock domain, straight to the transmitter [R9]
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= VPG_IDLE;
			line_no <= 16'h0000;
			byte_cnt <= 16'h0000;
			bar_cnt <= 16'h0000;
			bar_idx <= 3'd0;
			blk_idx <= 4'd0;
			fe_pending <= 1'b0;
			fe_sent <= 1'b0;
			tx <= '0;
			busy <= 1'b0;
			frame_cnt <= 16'h0000;
		end
		else if (accept)
		begin
			tx <= '0;
			case (state)
				VPG_IDLE:
				begin
					busy <= 1'b0;
					if (ctl_en) // [R1]
						state <= VPG_FS;
				end
				VPG_FS:
				begin
					// frame start short packet [R10]
					tx <= '{valid: 1'b1, sop: 1'b1, eop: 1'b1, short_pkt: 1'b1,
						vc: csi_di[7:6], dt: `VPG_DT_FS, wc: frame_cnt, data: 8'h00};
					busy <= 1'b1;
					line_no <= 16'h0000;
					fe_sent <= 1'b0;
					state <= VPG_WAIT;
				end
				VPG_WAIT:
				begin
					if (line_due)
					begin
						if (line_no + 16'd1 >= tot_lpf)
							state <= fe_sent ? (ctl_en ? VPG_FS : VPG_IDLE) : VPG_FE; // [R19] [R20]
						else if (line_no + 16'd1 == 16'(vbp) + act_lpf + 16'(vfp))
						begin
							// front porch done; frame end goes out now [R7]
							fe_pending <= 1'b1;
							state <= VPG_FE;
						end
						else
						begin
							line_no <= line_no + 16'd1;
							state <= VPG_HDR;
						end
					end
				end
				VPG_HDR:
				begin
					if (in_active)
					begin
						// long packet header with programmed type and channel [R5] [R10]
						tx <= '{valid: 1'b1, sop: 1'b1, eop: 1'b0, short_pkt: 1'b0,
							vc: csi_di[7:6], dt: csi_di[5:0], wc: line_size, data: 8'h00};
						byte_cnt <= 16'h0000;
						bar_cnt <= 16'h0000;
						bar_idx <= 3'd0;
						blk_idx <= 4'd0;
						state <= (line_size == 16'h0000) ? VPG_WAIT : VPG_DATA;
					end
					else
						state <= VPG_WAIT;
				end
				VPG_DATA:
				begin
					tx <= '{valid: 1'b1, sop: 1'b0, eop: byte_cnt + 16'd1 == line_size,
						short_pkt: 1'b0, vc: csi_di[7:6], dt: csi_di[5:0],
						wc: line_size, data: pix};
					byte_cnt <= byte_cnt + 16'd1;
					blk_idx <= (blk_idx == blk_m1) ? 4'd0 : blk_idx + 4'd1; // [R14]
					if (bar_cnt + 16'd1 >= bar_size && bar_idx != nbars_m1)
					begin
						bar_cnt <= 16'h0000;
						bar_idx <= bar_idx + 3'd1; // [R2] [R13]
					end
					else
						bar_cnt <= bar_cnt + 16'd1;
					if (byte_cnt + 16'd1 == line_size)
						state <= VPG_WAIT;
				end
				VPG_FE:
				begin
					// frame end, then restart or stop at the boundary [R10] [R20]
					tx <= '{valid: 1'b1, sop: 1'b1, eop: 1'b1, short_pkt: 1'b1,
						vc: csi_di[7:6], dt: `VPG_DT_FE, wc: frame_cnt, data: 8'h00};
					frame_cnt <= frame_cnt + 16'd1;
					if (fe_pending)
					begin
						fe_pending <= 1'b0;
						fe_sent <= 1'b1; // trailing blank lines end the frame without a second end
						line_no <= line_no + 16'd1;
						state <= VPG_WAIT;
					end
					else
						state <= ctl_en ? VPG_FS : VPG_IDLE; // [R19] [R20]
				end
				default: state <= VPG_IDLE;
			endcase
		end
	end

	// checks
	property p_fe_ends; // [R20]
		@(posedge core_clk) disable iff (!rst_n)
		(state == VPG_FE && accept && !fe_pending && !ctl_en) |=> state == VPG_IDLE;
	endproperty
	a_fe_ends: assert property (p_fe_ends) else $error("stop not at frame end"); // [R20]
	property p_fs_type; // [R10]
		@(posedge core_clk) disable iff (!rst_n)
		(state == VPG_FS && accept) |=> tx.valid && tx.short_pkt && tx.dt == `VPG_DT_FS;
	endproperty
	a_fs_type: assert property (p_fs_type) else $error("bad frame start"); // [R10]
	property p_first_bar; // [R2]
		@(posedge core_clk) disable iff (!rst_n)
		(state == VPG_DATA && accept && byte_cnt == 16'h0 && !cfg[`VPG_CFG_FIXED_BIT])
			|=> tx.data == 8'haa;
	endproperty
	a_first_bar: assert property (p_first_bar) else $error("first bar wrong"); // [R2]
	property p_bar_cap; // [R4]
		@(posedge core_clk) disable iff (!rst_n) bar_idx <= nbars_m1 || state != VPG_DATA;
	endproperty
	a_bar_cap: assert property (p_bar_cap) else $error("bar index overrun"); // [R4] [R3]
	property p_hdr_wc; // [R5]
		@(posedge core_clk) disable iff (!rst_n)
		(tx.valid && tx.sop && !tx.short_pkt) |-> tx.wc == line_size && tx.dt == csi_di[5:0];
	endproperty
	a_hdr_wc: assert property (p_hdr_wc) else $error("header fields wrong"); // [R5]
	property p_blk_wrap; // [R14]
		@(posedge core_clk) disable iff (!rst_n) blk_idx <= blk_m1 || state != VPG_DATA;
	endproperty
	a_blk_wrap: assert property (p_blk_wrap) else $error("block index overrun"); // [R14]
	property p_hold; // [R9]
		@(posedge core_clk) disable iff (!rst_n) (tx.valid && !tx_ready) |=> $stable(tx);
	endproperty
	a_hold: assert property (p_hold) else $error("output changed while stalled"); // [R9]
	property p_idle_start; // [R1]
		@(posedge core_clk) disable iff (!rst_n)
		(state == VPG_IDLE && ctl_en && accept) |=> state == VPG_FS;
	endproperty
	a_idle_start: assert property (p_idle_start) else $error("enable ignored"); // [R1]
	c_fixed: cover property (@(posedge core_clk) state == VPG_DATA && cfg[`VPG_CFG_FIXED_BIT]);
	c_fe: cover property (@(posedge core_clk) tx.valid && tx.dt == `VPG_DT_FE && tx.short_pkt);
	c_last_bar: cover property (@(posedge core_clk) state == VPG_DATA && bar_idx == 3'd7);
endmodule : vpg_top
`default_nettype wire

/* sim/vpg_sink.sv */
// transmitter stand-in: takes beats with random stalls and reports each one it accepted
`timescale 1ns/100ps
`default_nettype none
module vpg_sink
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// stream from the generator
	input wire vpg_pkg::vpg_tx_t tx,
	output logic tx_ready,
	// accepted beat, one cycle late
	output vpg_pkg::vpg_tx_t got,
	output logic got_stb
);
	import vpg_pkg::*;
	int seed = 32'hd7706182;
	// ready drops at random to stall the generator; a held beat is counted once, when taken
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_ready <= 1'b0;
			got_stb <= 1'b0;
			got <= '0;
		end
		else
		begin
			tx_ready <= ($random(seed) & 3) != 0;
			got_stb <= tx.valid && tx_ready;
			got <= tx;
		end
	end
endmodule : vpg_sink
`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench for the pattern generator
`timescale 1ns/100ps
`default_nettype none
`include "vpg_map.svh"
`define CHK(x, y) \
	begin \
		n_compared++; \
		if ((x) !== (y)) \
		begin \
			mismatches++; \
			$display("BAD t=%0t got %h exp %h", $time, (x), (y)); \
		end \
	end
module tb_top;
	import vpg_pkg::*;
	logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic pready, pslverr, tx_ready, got_stb, busy, fixm, inv;
	logic [1:0] vc;
	logic [7:0] fix [16];
	logic [7:0] bars [8] = '{8'haa, 8'h33, 8'hf0, 8'h7f, 8'h55, 8'hcc, 8'h0f, 8'h80};
	logic [11:0] offs [6] = '{`VPG_OFF_LINE_SIZE, `VPG_OFF_BAR_SIZE, `VPG_OFF_ACT_LPF,
		`VPG_OFF_TOT_LPF, `VPG_OFF_LINE_PD, `VPG_OFF_CSI_DI};
	logic [31:0] rsts [6] = '{32'(`VPG_RST_LINE_SIZE), 32'(`VPG_RST_BAR_SIZE),
		32'(`VPG_RST_ACT_LPF), 32'(`VPG_RST_TOT_LPF), 32'(`VPG_RST_LINE_PD), 32'(`VPG_RST_CSI_DI)};
	vpg_tx_t tx, got;
	vpg_tx_t q[$];
	int mismatches = 0, n_compared = 0, seed = 32'hd7706182;
	int line, bar, nbl, blk, nfe = 0;

	always #12.5 core_clk = ~core_clk;

	vpg_top uut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tx(tx), .tx_ready(tx_ready), .busy(busy));
	vpg_sink sink (.core_clk(core_clk), .rst_n(rst_n), .tx(tx), .tx_ready(tx_ready),
		.got(got), .got_stb(got_stb));

	// accepted beats queued for the frame checker
	always @(posedge core_clk)
		if (got_stb === 1'b1)
			q.push_back(got);

	task automatic stop_test();
		if (mismatches == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test

	// one apb transfer; the request holds until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		// no wait-state count assumed; the watchdog ends a hang
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr

	// next accepted beat, bounded wait
	task automatic pop(output vpg_tx_t b);
		int n;
		n = 0;
		b = '0;
		while (q.size() == 0 && n < 5000)
		begin
			@(posedge core_clk);
			n++;
		end
		if (q.size() == 0)
		begin
			mismatches++;
			stop_test();
		end
		b = q.pop_front();
	endtask : pop

	// byte i of an active line; last bar takes any leftover bytes
	function automatic logic [7:0] exp_byte(int i);
		int k;
		logic [7:0] v;
		k = i / bar;
		if (k > nbl - 1)
			k = nbl - 1;
		v = fixm ? fix[i % blk] : bars[k];
		return (fixm && inv && k[0]) ? ~v : v;
	endfunction : exp_byte

	// one whole frame; disable goes in mid-frame when last is set
	task automatic check_frame(input bit last);
		vpg_tx_t b;
		pop(b);
		`CHK({b.short_pkt, b.dt, b.wc}, {1'b1, `VPG_DT_FS, nfe[15:0]})
		if (last)
			wr(`VPG_OFF_CTL, 32'h0);
		repeat (2)
		begin
			pop(b);
			`CHK({b.sop, b.short_pkt, b.vc, b.dt, b.wc}, {2'b10, vc, 6'h24, line[15:0]})
			for (int i = 0; i < line; i++)
			begin
				pop(b);
				`CHK({b.data, b.eop}, {exp_byte(i), i == line - 1})
			end
		end
		pop(b);
		`CHK({b.short_pkt, b.dt, b.wc}, {1'b1, `VPG_DT_FE, nfe[15:0]})
		nfe++;
	endtask : check_frame

	// program a random geometry, run frames, then see the stream stop
	task automatic run(input logic fx, input logic iv, input int nlog, input int nfr,
		input logic slow);
		int n;
		logic [31:0] r;
		logic e;
		// rgb888 geometry: bars, line and block all in whole 3-byte pixels
		bar = 3 * (1 + $unsigned($random(seed)) % 2);
		nbl = 1 << nlog;
		line = nbl * bar + 3 * ($unsigned($random(seed)) % 3);
		blk = 3 * (1 + $unsigned($random(seed)) % 5);
		vc = 2'($random(seed));
		fixm = fx;
		inv = iv;
		for (int k = 0; k < 16; k++)
		begin
			fix[k] = 8'($random(seed));
			wr(`VPG_OFF_FIXED + 12'(4 * k), {24'h0, fix[k]});
		end
		wr(`VPG_OFF_CFG, {24'h0, fx, iv, nlog[1:0], 4'(blk - 1)});
		wr(`VPG_OFF_CSI_DI, {24'h0, vc, 6'h24});
		wr(`VPG_OFF_LINE_SIZE, 32'(line));
		wr(`VPG_OFF_BAR_SIZE, 32'(bar));
		wr(`VPG_OFF_ACT_LPF, 32'h2);
		wr(`VPG_OFF_TOT_LPF, 32'h5);
		wr(`VPG_OFF_LINE_PD, 32'h4);
		wr(`VPG_OFF_VBP, 32'h1);
		wr(`VPG_OFF_VFP, 32'h1);
		wr(`VPG_OFF_CTL, {30'h0, slow, 1'b1});
		for (int f = 0; f < nfr; f++)
			check_frame(f == nfr - 1);
		n = 0;
		while (busy !== 1'b0 && n < 3000)
		begin
			@(posedge core_clk);
			n++;
		end
		repeat (60) @(posedge core_clk);
		`CHK({busy, q.size()}, 33'h0)
		apb(1'b0, `VPG_OFF_CFG, 32'h0, r, e);
		`CHK({e, r}, {25'h0, fx, iv, nlog[1:0], 4'(blk - 1)})
		apb(1'b0, `VPG_OFF_STATUS, 32'h0, r, e);
		`CHK({e, r}, {1'b0, nfe[15:0], 16'h0000})
	endtask : run

	// main sequence
	initial
	begin
		logic [31:0] r;
		logic e;
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		for (int k = 0; k < 6; k++)
		begin
			apb(1'b0, offs[k], 32'h0, r, e);
			`CHK({e, r}, {1'b0, rsts[k]})
		end
		apb(1'b0, 12'h100, 32'h0, r, e);
		`CHK({e, r}, 33'h100000000)
		for (int k = 0; k < 4; k++)
			run(1'b0, 1'b0, k, k == 3 ? 2 : 1, k[0]);
		run(1'b1, 1'b1, 2, 1, 1'b0);
		run(1'b1, 1'b0, 0, 1, 1'b1);
		stop_test();
	end

	// watchdog against a hang
	initial
	begin
		#(25 * 80000);
		mismatches++;
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
